// ===== hdl/wdkw_top.sv
// wdkw_top: watchdog with key service, reset or interrupt pulse, and
// low power mode selection with qualified standby wake inputs.
// assumes register strobes from clk_sys logic and wake pins from outside.
// Notes on behaviour
// - mode field: 00 idle, 01 standby, 1x halt
// - mode used only on idle instruction
// - wake qualification lasts field plus two cycles
// - enabled wake bits let their input wake
// - device reset clears all wake enables
// - counter at maximum gives 512-cycle pulse
// - software can disable the counter
// - reset pulse drives both reset outputs low
// - interrupt mode drives irq low 512 cycles
// - key 0x55 arms the counter clear
// - armed 0xAA clears counter, otherwise nothing
// - a clear consumes the arm state
// - any other key fires the watchdog event
// - bad key resets or interrupts per mode
// - reset-mode events set surviving reset flag
// - software clears flag; resets still happen
// - counter ticks at divided rate when enabled
// - wake inputs qualified before waking
// - switch to reset while irq low resets
`timescale 1ns/1ps
module wdkw_top
    import wdkw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // wake pins, bit order as standby_wake_enable
    input wire logic [15:0] wake_pins,
    // watchdog outputs
    output logic timeout_reset_out_n,
    output logic device_reset_pin_n,
    output logic timeout_irq_out_n,
    // power state
    output logic standby_active,
    output logic halt_active,
    output logic wake_event
);
    // register state
    logic [15:0] power_mode;
    logic [15:0] wake_enable;
    logic counter_disable;
    logic irq_mode;
    logic timeout_reset_flag;
    logic [7:0] timeout_counter;
    logic [8:0] tick_div;
    logic key_armed;
    wdkw_mode_e mode;
    logic [15:0] next_power_mode;
    logic [15:0] next_wake_enable;
    logic next_counter_disable;
    logic next_irq_mode;
    logic next_flag;
    logic [7:0] next_counter;
    logic [8:0] next_tick_div;
    logic next_armed;
    wdkw_mode_e next_mode;
    logic [15:0] next_rdata;
    logic next_wake_event;
    // wake pin synchronisers
    logic [15:0] wake_meta;
    logic [15:0] wake_sync;
    logic [15:0] wake_src;
    logic [15:0] wake_ok;
    logic wake_any;
    // event wiring
    logic tick;
    logic overflow;
    logic bad_key;
    logic wd_event;
    logic reset_trigger;
    logic irq_trigger;
    logic reset_pulse_n;
    logic irq_pulse_n;
    logic [6:0] need;
    logic wr_ctrl;
    logic wr_key;

    // decode a write to one register index
    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx,
                                 input logic stb);
        hit = stb && (a == idx);
    endfunction

    // synchronise the wake pins, first stage read only by the second
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake_meta <= 16'h0000;
            wake_sync <= 16'h0000;
        end else begin
            wake_meta <= wake_pins;
            wake_sync <= wake_meta;
        end
    end

    // watchdog irq wakes from bit 2, level from the pulse stage
    always_comb begin
        wake_src = wake_sync;
        wake_src[2] = ~irq_pulse_n;
    end

    // qualify each enabled wake source
    assign need = {1'b0, power_mode[QUAL_LSB +: QUAL_W]} + QUAL_OFFSET;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_wake
            wdkw_qualify u_qual (
                .clk_sys(clk_sys),
                .reset(reset),
                .wake_in(wake_src[gi] & wake_enable[gi]),
                .need(need),
                .qualified(wake_ok[gi])
            );
        end
    endgenerate
    assign wake_any = |wake_ok;

    // event decode
    assign wr_ctrl = hit(reg_addr, ADDR_TIMEOUT_CTRL, reg_write);
    assign wr_key = hit(reg_addr, ADDR_SERVICE_KEY, reg_write);
    assign tick = (tick_div == TICK_LAST);
    assign overflow = !counter_disable && tick && (timeout_counter == COUNT_MAX);
    assign bad_key = wr_key && (reg_wdata[7:0] != KEY_ARM)
        && (reg_wdata[7:0] != KEY_CLEAR);
    assign wd_event = overflow || bad_key;
    assign reset_trigger = (wd_event && !irq_mode)
        || (wr_ctrl && !reg_wdata[CTRL_IRQ_MODE_BIT] && !irq_pulse_n);
    assign irq_trigger = wd_event && irq_mode;

    // next state of registers, counter and mode
    always_comb begin
        next_power_mode = power_mode;
        next_wake_enable = wake_enable;
        next_counter_disable = counter_disable;
        next_irq_mode = irq_mode;
        next_flag = timeout_reset_flag;
        next_counter = timeout_counter;
        next_tick_div = tick_div + 9'h001;
        next_armed = key_armed;
        next_mode = mode;
        next_wake_event = 1'b0;
        if (hit(reg_addr, ADDR_POWER_MODE, reg_write)) begin
            next_power_mode = reg_wdata & POWER_MODE_MASK;
        end
        if (hit(reg_addr, ADDR_WAKE_ENABLE, reg_write)) begin
            next_wake_enable = reg_wdata;
        end
        if (wr_ctrl) begin
            next_counter_disable = reg_wdata[CTRL_DISABLE_BIT];
            next_irq_mode = reg_wdata[CTRL_IRQ_MODE_BIT];
            if (reg_wdata[CTRL_FLAG_BIT]) begin
                next_flag = 1'b0;
            end
        end
        // counter runs on the divided tick
        if (counter_disable) begin
            next_tick_div = 9'h000;
        end else if (tick) begin
            next_counter = timeout_counter + 8'h01;
            next_tick_div = 9'h000; // divider restarts on each tick
        end
        // key service
        if (wr_key && reg_wdata[7:0] == KEY_ARM) begin
            next_armed = 1'b1;
        end else if (wr_key && reg_wdata[7:0] == KEY_CLEAR && key_armed) begin
            next_counter = 8'h00;
            next_tick_div = 9'h000;
            next_armed = 1'b0;
        end
        // flag set wins over a clear in the same cycle
        if (reset_trigger) begin
            next_flag = 1'b1;
            next_armed = 1'b0;
            next_counter = 8'h00;
            next_tick_div = 9'h000;
        end
        // power mode entered only on the idle instruction
        case (mode)
            WDKW_RUN: begin
                if (hit(reg_addr, ADDR_IDLE_CMD, reg_write)) begin
                    if (power_mode[MODE_LSB + 1]) begin
                        next_mode = WDKW_HALT;
                    end else if (power_mode[MODE_LSB]) begin
                        next_mode = WDKW_STANDBY;
                    end
                end
            end
            WDKW_STANDBY: begin
                if (wake_any) begin
                    next_mode = WDKW_RUN;
                    next_wake_event = 1'b1;
                end
            end
            WDKW_HALT: begin
                next_mode = WDKW_HALT;
            end
            default: begin
                next_mode = WDKW_RUN;
            end
        endcase
        // read data
        next_rdata = 16'h0000;
        if (reg_read) begin
            case (reg_addr)
                ADDR_POWER_MODE: next_rdata = power_mode;
                ADDR_WAKE_ENABLE: next_rdata = wake_enable;
                ADDR_SERVICE_KEY, ADDR_TIMEOUT_CTRL: begin
                    next_rdata[CTRL_DISABLE_BIT] = counter_disable;
                    next_rdata[CTRL_IRQ_MODE_BIT] = irq_mode;
                    next_rdata[CTRL_FLAG_BIT] = timeout_reset_flag;
                end
                ADDR_TIMEOUT_STATUS: begin
                    next_rdata[7:0] = timeout_counter;
                    next_rdata[STAT_IRQ_LEVEL_BIT] = irq_pulse_n;
                    next_rdata[STAT_STANDBY_BIT] = (mode == WDKW_STANDBY);
                    next_rdata[STAT_HALT_BIT] = (mode == WDKW_HALT);
                end
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // register all state; the flag survives the watchdog's own reset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            power_mode <= POWER_MODE_RESET;
            wake_enable <= WAKE_ENABLE_RESET;
            counter_disable <= TIMEOUT_CTRL_RESET[CTRL_DISABLE_BIT];
            irq_mode <= TIMEOUT_CTRL_RESET[CTRL_IRQ_MODE_BIT];
            timeout_reset_flag <= TIMEOUT_CTRL_RESET[CTRL_FLAG_BIT];
            timeout_counter <= 8'h00;
            tick_div <= 9'h000;
            key_armed <= 1'b0;
            mode <= WDKW_RUN;
            reg_rdata <= 16'h0000;
            wake_event <= 1'b0;
        end else begin
            power_mode <= next_power_mode;
            wake_enable <= next_wake_enable;
            counter_disable <= next_counter_disable;
            irq_mode <= next_irq_mode;
            timeout_reset_flag <= next_flag;
            timeout_counter <= next_counter;
            tick_div <= next_tick_div;
            key_armed <= next_armed;
            mode <= next_mode;
            reg_rdata <= next_rdata;
            wake_event <= next_wake_event;
        end
    end

    // reset and interrupt pulse stretchers
    wdkw_pulse u_reset_pulse (
        .clk_sys(clk_sys),
        .reset(reset),
        .trigger(reset_trigger),
        .pulse_n(reset_pulse_n)
    );
    wdkw_pulse u_irq_pulse (
        .clk_sys(clk_sys),
        .reset(reset),
        .trigger(irq_trigger),
        .pulse_n(irq_pulse_n)
    );

    // outputs straight from flip-flops
    assign timeout_reset_out_n = reset_pulse_n;
    assign device_reset_pin_n = reset_pulse_n;
    assign timeout_irq_out_n = irq_pulse_n;
    assign standby_active = mode[1];
    assign halt_active = mode[2];
endmodule // wdkw_top

// ===== hdl/wdkw_pkg.sv
// wdkw_pkg: constants for the watchdog key service and standby wake block
// assumes a 200 MHz oscillator clock and a plain 16-bit register port
package wdkw_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_POWER_MODE = 4'h0; // low_power_mode_control
    localparam logic [3:0] ADDR_WAKE_ENABLE = 4'h1; // standby_wake_enable
    localparam logic [3:0] ADDR_SERVICE_KEY = 4'h2; // service_key
    localparam logic [3:0] ADDR_TIMEOUT_CTRL = 4'h3; // timeout_control
    localparam logic [3:0] ADDR_TIMEOUT_STATUS = 4'h4; // status and counter
    localparam logic [3:0] ADDR_IDLE_CMD = 4'h5; // idle instruction strobe
    // low_power_mode_control fields
    localparam int MODE_LSB = 0;
    localparam int QUAL_LSB = 2;
    localparam int QUAL_W = 6;
    localparam logic [15:0] POWER_MODE_RESET = 16'h0000;
    localparam logic [15:0] POWER_MODE_MASK = 16'h00ff;
    localparam logic [15:0] WAKE_ENABLE_RESET = 16'h0000;
    localparam logic [6:0] QUAL_OFFSET = 7'h02;
    // timeout_control fields
    localparam int CTRL_DISABLE_BIT = 0;
    localparam int CTRL_IRQ_MODE_BIT = 1;
    localparam int CTRL_FLAG_BIT = 2; // write one to clear
    localparam logic [15:0] TIMEOUT_CTRL_RESET = 16'h0000;
    // timeout_status fields
    localparam int STAT_IRQ_LEVEL_BIT = 8;
    localparam int STAT_STANDBY_BIT = 9;
    localparam int STAT_HALT_BIT = 10;
    // service keys
    localparam logic [7:0] KEY_ARM = 8'h55;
    localparam logic [7:0] KEY_CLEAR = 8'haa;
    // counter and pulse timing
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam int PULSE_CYCLES = 512;
    localparam logic [9:0] PULSE_LEN = 10'(PULSE_CYCLES);
    localparam int TICK_DIV = 64; // oscillator cycles per tick, keeps overflow reachable
    localparam logic [8:0] TICK_LAST = 9'(TICK_DIV - 1);
    // power modes
    typedef enum logic [2:0] {
        WDKW_RUN = 3'b001,
        WDKW_STANDBY = 3'b010,
        WDKW_HALT = 3'b100
    } wdkw_mode_e;
endpackage

// ===== hdl/wdkw_pulse.sv
// wdkw_pulse: stretches a one-cycle trigger into a fixed-length low pulse
// assumes trigger from logic on clk_sys; retrigger while busy is ignored
`timescale 1ns/1ps
module wdkw_pulse
    import wdkw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // trigger in, pulse out
    input wire logic trigger,
    output logic pulse_n
);
    logic [9:0] remain;
    logic [9:0] next_remain;
    logic next_pulse_n;

    // count down the low time
    always_comb begin
        next_remain = remain;
        if (remain != 10'h000) begin
            next_remain = remain - 10'h001;
        end else if (trigger) begin
            next_remain = PULSE_LEN;
        end
        next_pulse_n = (next_remain == 10'h000);
    end

    // register the pulse state
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            remain <= 10'h000;
            pulse_n <= 1'b1;
        end else begin
            remain <= next_remain;
            pulse_n <= next_pulse_n;
        end
    end
endmodule // wdkw_pulse

// ===== hdl/wdkw_qualify.sv
// wdkw_qualify: one wake input held high for a programmed run of cycles
// assumes the input is already synchronised to clk_sys
`timescale 1ns/1ps
module wdkw_qualify
    import wdkw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // wake input and required length
    input wire logic wake_in,
    input wire logic [6:0] need,
    output logic qualified
);
    logic [6:0] run;
    logic [6:0] next_run;

    // count consecutive high cycles, saturating at the need
    always_comb begin
        next_run = 7'h00;
        if (wake_in) begin
            next_run = (run >= need) ? run : run + 7'h01;
        end
    end

    // register the run length
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run <= 7'h00;
        end else begin
            run <= next_run;
        end
    end

    assign qualified = wake_in && (run + 7'h01 >= need);
endmodule // wdkw_qualify

// ===== tb/wdkw_top_monitor.sv
// wdkw_top_monitor: port-level checks for the watchdog and wake block
// assumes binding onto wdkw_top, one clk_sys domain, async reset
`timescale 1ns/1ps
module wdkw_top_monitor
    import wdkw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    // pins and state
    input wire logic [15:0] wake_pins,
    input wire logic timeout_reset_out_n,
    input wire logic device_reset_pin_n,
    input wire logic timeout_irq_out_n,
    input wire logic standby_active,
    input wire logic halt_active,
    input wire logic wake_event
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [9:0] rst_low;
    logic [9:0] irq_low;
    logic idle_q;
    // low-cycle counts of both pulses, idle strobe seen
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rst_low <= 10'h000;
            irq_low <= 10'h000;
            idle_q <= 1'b0;
        end else begin
            rst_low <= timeout_reset_out_n ? 10'h000 : rst_low + 10'h001;
            irq_low <= timeout_irq_out_n ? 10'h000 : irq_low + 10'h001;
            idle_q <= reg_write && reg_addr == ADDR_IDLE_CMD;
        end
    end
    sequence s_bad_key;
        reg_write && reg_addr == ADDR_SERVICE_KEY && reg_wdata[7:0] != KEY_ARM
            && reg_wdata[7:0] != KEY_CLEAR && timeout_reset_out_n && timeout_irq_out_n;
    endsequence
    sequence s_pulse_low;
        !timeout_reset_out_n || !timeout_irq_out_n;
    endsequence
    a_bad_key_fires: assert property (s_bad_key |=> s_pulse_low)
        else $error("bad key gave no pulse");
    a_pin_copy: assert property (device_reset_pin_n == timeout_reset_out_n)
        else $error("reset pin differs from reset out");
    a_reset_len: assert property ($rose(timeout_reset_out_n) |-> rst_low == PULSE_LEN)
        else $error("reset pulse length wrong");
    a_irq_len: assert property ($rose(timeout_irq_out_n) |-> irq_low == PULSE_LEN)
        else $error("irq pulse length wrong");
    a_pulse_bound: assert property (rst_low <= PULSE_LEN && irq_low <= PULSE_LEN)
        else $error("pulse too long");
    a_irq_to_reset: assert property (reg_write && reg_addr == ADDR_TIMEOUT_CTRL
        && !reg_wdata[CTRL_IRQ_MODE_BIT] && !timeout_irq_out_n && timeout_reset_out_n
        |=> !timeout_reset_out_n)
        else $error("mode switch during irq gave no reset");
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_mode_on_idle: assert property ($rose(standby_active) || $rose(halt_active) |-> idle_q)
        else $error("mode entered without idle");
    a_halt_holds: assert property (halt_active |=> halt_active && !standby_active)
        else $error("halt left or mixed");
    a_wake_exit: assert property (wake_event |-> !standby_active ##1 !wake_event)
        else $error("wake pulse wrong");
endmodule // wdkw_top_monitor

bind wdkw_top wdkw_top_monitor u_monitor (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .wake_pins(wake_pins),
    .timeout_reset_out_n(timeout_reset_out_n), .device_reset_pin_n(device_reset_pin_n),
    .timeout_irq_out_n(timeout_irq_out_n), .standby_active(standby_active),
    .halt_active(halt_active), .wake_event(wake_event));

// ===== tb/wdkw_top_test.sv
// wdkw_top_test: self-checking bench for key service, pulses, power modes
// assumes wdkw_top on 200 MHz clk_sys, monitor bound alongside
`timescale 1ns/1ps
module wdkw_top_test
    import wdkw_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] wake_pins = 16'h0000;
    logic [15:0] reg_rdata;
    logic rst_n, pin_n, irq_n, stby, halt, wake;
    logic [15:0] d;
    logic [7:0] k;
    int failures = 0;
    int comparisons = 0;
    int n, q, b;
    // reference model of the programmable registers
    int m_pwr = 0;
    int m_wake = 0;
    int m_ctrl = 0;
    // register read value predicted by the model
    function automatic logic [15:0] m_read(input logic [3:0] a);
        case (a)
            ADDR_POWER_MODE: m_read = 16'(m_pwr);
            ADDR_WAKE_ENABLE: m_read = 16'(m_wake);
            ADDR_SERVICE_KEY, ADDR_TIMEOUT_CTRL: m_read = 16'(m_ctrl);
            default: m_read = 16'h0000;
        endcase
    endfunction
    wdkw_top u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .wake_pins(wake_pins), .timeout_reset_out_n(rst_n),
        .device_reset_pin_n(pin_n), .timeout_irq_out_n(irq_n),
        .standby_active(stby), .halt_active(halt), .wake_event(wake));
    // 5 ns clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write, returns once its effect has landed
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        case (a)
            ADDR_POWER_MODE: m_pwr = v & POWER_MODE_MASK;
            ADDR_WAKE_ENABLE: m_wake = v;
            ADDR_TIMEOUT_CTRL: m_ctrl = (v & 3) | (m_ctrl & ~v & 4);
            ADDR_SERVICE_KEY: begin
                if (v[7:0] != KEY_ARM && v[7:0] != KEY_CLEAR && !m_ctrl[1]) begin
                    m_ctrl = m_ctrl | 4;
                end
            end
            default: ;
        endcase
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rst();
        @(posedge clk_sys);
        reset <= 1'b1;
        m_pwr = POWER_MODE_RESET;
        m_wake = WAKE_ENABLE_RESET;
        m_ctrl = TIMEOUT_CTRL_RESET;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
    endtask
    // cycles a pulse stays low, launch cycle included
    task automatic width(input int sel, output int w);
        w = 0;
        while (w < 600 && !(sel ? irq_n : rst_n)) begin
            w++;
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic test_done();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, roughly twice the expected run
    initial begin
        #200000;
        failures++;
        test_done();
    end
    initial begin
        void'($urandom(24177));
        rst();
        // reset values, unmapped index ignored
        wr(4'hf, 16'hffff);
        for (int a = 0; a < 4; a++) begin
            rd(4'(a), d);
            chk(d, m_read(4'(a)));
        end
        rd(4'hf, d);
        chk(d, m_read(4'hf));
        wr(ADDR_POWER_MODE, 16'hffff);
        rd(ADDR_POWER_MODE, d);
        chk(d, m_read(ADDR_POWER_MODE));
        wr(ADDR_POWER_MODE, 16'h0000);
        // counting and disable
        repeat (1100) @(posedge clk_sys);
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0] != 8'h00), 16'h0001);
        wr(ADDR_TIMEOUT_CTRL, 16'h0001);
        rd(ADDR_TIMEOUT_STATUS, d);
        k = d[7:0];
        repeat (1100) @(posedge clk_sys);
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0]), 16'(k));
        wr(ADDR_TIMEOUT_CTRL, 16'h0000);
        // key sequences: lone clear, arm twice, clear, stale clear
        wr(ADDR_SERVICE_KEY, 16'(KEY_CLEAR));
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0] != 8'h00), 16'h0001);
        wr(ADDR_SERVICE_KEY, 16'(KEY_ARM));
        wr(ADDR_SERVICE_KEY, 16'(KEY_ARM));
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0] != 8'h00), 16'h0001);
        wr(ADDR_SERVICE_KEY, 16'(KEY_CLEAR));
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0]), 16'h0000);
        repeat (1100) @(posedge clk_sys);
        wr(ADDR_SERVICE_KEY, 16'(KEY_CLEAR));
        rd(ADDR_TIMEOUT_STATUS, d);
        chk(16'(d[7:0] != 8'h00), 16'h0001);
        chk({14'h0000, rst_n, irq_n}, 16'h0003);
        // bad key in reset mode, twice, flag survives
        k = 8'($urandom);
        while (k == KEY_ARM || k == KEY_CLEAR) k = 8'($urandom);
        for (int r = 0; r < 2; r++) begin
            wr(ADDR_SERVICE_KEY, {8'($urandom), k});
            chk(16'(irq_n), 16'h0001);
            width(0, n);
            chk(16'(n), 16'(PULSE_CYCLES));
            rd(ADDR_TIMEOUT_CTRL, d);
            chk(d, m_read(ADDR_TIMEOUT_CTRL));
        end
        wr(ADDR_TIMEOUT_CTRL, 16'h0004);
        rd(ADDR_SERVICE_KEY, d);
        chk(d, m_read(ADDR_SERVICE_KEY));
        // interrupt mode, then switch back while low
        wr(ADDR_TIMEOUT_CTRL, 16'h0002);
        wr(ADDR_SERVICE_KEY, {8'h00, k});
        chk(16'(rst_n), 16'h0001);
        width(1, n);
        chk(16'(n), 16'(PULSE_CYCLES));
        wr(ADDR_SERVICE_KEY, {8'h00, k});
        repeat (20) @(posedge clk_sys);
        wr(ADDR_TIMEOUT_CTRL, 16'h0000);
        m_ctrl = m_ctrl | 4; // the switch fires a reset-mode event
        chk(16'(rst_n), 16'h0000);
        rd(ADDR_TIMEOUT_CTRL, d);
        chk(d, m_read(ADDR_TIMEOUT_CTRL));
        repeat (600) @(posedge clk_sys);
        // every mode code, entered only on idle
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_POWER_MODE, 16'(m));
            chk({14'h0000, halt, stby}, 16'h0000);
            wr(ADDR_IDLE_CMD, 16'h0000);
            chk({14'h0000, halt, stby}, m > 1 ? 16'h0002 : 16'(m));
            rst();
        end
        // wake from standby through one enabled pin
        q = $urandom % 64;
        b = $urandom % 16;
        if (b == 2) b = 3;
        wr(ADDR_WAKE_ENABLE, 16'h0001 << b);
        wr(ADDR_POWER_MODE, 16'(q << QUAL_LSB) | 16'h0001);
        wr(ADDR_IDLE_CMD, 16'h0000);
        wake_pins <= ~(16'h0001 << b);
        repeat (100) @(posedge clk_sys);
        wake_pins <= 16'h0001 << b;
        repeat (q + 1) @(posedge clk_sys);
        wake_pins <= 16'h0000;
        repeat (20) @(posedge clk_sys);
        #1 chk(16'(stby), 16'h0001);
        @(posedge clk_sys);
        wake_pins <= 16'h0001 << b;
        n = 0;
        while (!wake && n < 300) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(16'(n >= q + 2 && n <= q + 8 && !stby), 16'h0001);
        wake_pins <= 16'h0000;
        // device reset clears wake enables; the unserviced counter then overflows
        wr(ADDR_WAKE_ENABLE, 16'hffff);
        rst();
        n = 0;
        while (rst_n && n < 20000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(16'(n), 16'(256 * TICK_DIV));
        chk(16'(irq_n), 16'h0001);
        m_ctrl = m_ctrl | 4; // overflow in reset mode raises the flag
        rd(ADDR_TIMEOUT_CTRL, d);
        chk(d, m_read(ADDR_TIMEOUT_CTRL));
        rd(ADDR_WAKE_ENABLE, d);
        chk(d, m_read(ADDR_WAKE_ENABLE));
        test_done();
    end
endmodule // wdkw_top_test
